// ---- hw/stw_scan_limit_watchdog.sv ----
`timescale 1ns/1ps
// Overview of operation
// - The timeout setting accepts 5 to 120 ticks of 10 ms, 50 ms to 1.2 s.
// - A set-timeout command, by level or rising edge, loads N times 10 ms.
// - A scan exceeding the timeout without retrigger shuts the controller.
// - On expiry every I/O point is forced off regardless of the processor.
// - A loaded timeout is kept until it is loaded again or a reset restores the 25-tick default.
// - Without any load the timeout is a quarter of a second.
// - A retrigger command, by level or rising edge, clears the count to 0.
// - Each trigger is a one-shot restart from zero.
// - Unretriggered, the count rises until it equals N and the dog fires.
// - Timing runs in dedicated hardware that software cannot stop.
module stw_scan_limit_watchdog #(
  parameter int unsigned TICK_CYCLES = stw_pkg::TICK_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       set_timeout_command,
  input  wire logic [6:0] set_timeout_ticks,
  input  wire logic       set_timeout_edge_mode,
  input  wire logic       retrigger_command,
  input  wire logic       retrigger_edge_mode,
  output logic            controller_halt,
  output logic            io_outputs_off,
  output logic [6:0]      timeout_limit,
  output logic [6:0]      elapsed_ticks,
  output logic            setting_rejected
);

  // Elaboration checks. The divider needs at least two cycles per tick,
  // and the package limits must form a non-empty range that holds the
  // default, otherwise a reset would leave the dog with an illegal limit.
  initial begin
    if (TICK_CYCLES < 2) begin
      $error("stw_scan_limit_watchdog: TICK_CYCLES too small");
    end
    if (stw_pkg::LIMIT_MIN > stw_pkg::LIMIT_MAX) begin
      $error("stw_scan_limit_watchdog: limit range is empty");
    end
    if (stw_pkg::LIMIT_DEFAULT < stw_pkg::LIMIT_MIN ||
        stw_pkg::LIMIT_DEFAULT > stw_pkg::LIMIT_MAX) begin
      $error("stw_scan_limit_watchdog: default limit out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command qualification.

  logic             set_prev_q;
  logic             rtg_prev_q;
  logic             set_fire;
  logic             rtg_fire;
  logic             tick;
  logic             expire;
  stw_pkg::stw_state_t state_q;
  stw_pkg::stw_load_t  load;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      set_prev_q <= 1'b0;
      rtg_prev_q <= 1'b0;
    end else begin
      set_prev_q <= set_timeout_command;
      rtg_prev_q <= retrigger_command;
    end
  end

  // Edge mode needs the command low on the previous edge. Level mode fires
  // on every high cycle, so a command that is stuck high keeps restarting
  // the count; that is the documented behaviour, and edge mode is the
  // choice for users who want a stuck retrigger line to be caught.
  function automatic logic cmd_fire(input logic edge_mode,
                                    input logic cmd,
                                    input logic prev);
    if (edge_mode) begin
      cmd_fire = cmd & ~prev;
    end else begin
      cmd_fire = cmd;
    end
  endfunction

  always_comb begin
    set_fire   = cmd_fire(set_timeout_edge_mode, set_timeout_command,
                          set_prev_q);
    rtg_fire   = cmd_fire(retrigger_edge_mode, retrigger_command,
                          rtg_prev_q);
    load.load  = set_fire;
    load.ticks = set_timeout_ticks;
  end

  function automatic logic in_range(input logic [6:0] n);
    in_range = (n >= stw_pkg::LIMIT_MIN) && (n <= stw_pkg::LIMIT_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timeout limit. Out-of-range settings are refused and the old limit kept,
  // so an out-of-range operand never changes the limit, though its load still restarts the count.

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timeout_limit    <= stw_pkg::LIMIT_DEFAULT;
      setting_rejected <= 1'b0;
    end else if (load.load) begin
      if (in_range(load.ticks)) begin
        timeout_limit    <= load.ticks;
        setting_rejected <= 1'b0;
      end else begin
        setting_rejected <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick divider; a retrigger or any load command, accepted or refused, restarts it with the count.

  stw_tick_div #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .reset    (reset),
    .restart  (rtg_fire | set_fire),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Elapsed count and expiry.

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      elapsed_ticks <= '0;
    end else if (state_q == stw_pkg::STW_EXPIRED) begin
      elapsed_ticks <= elapsed_ticks;
    end else if (rtg_fire || set_fire) begin
      elapsed_ticks <= '0;
    end else if (tick && elapsed_ticks < timeout_limit) begin
      elapsed_ticks <= elapsed_ticks + 7'h01;
    end
  end

  // Expiry decision. A fire in the same cycle wins over reaching the limit,
  // so a retrigger that lands exactly on time still keeps the machine up.
  always_comb begin
    expire = 1'b0;
    if (state_q == stw_pkg::STW_ARMED && !rtg_fire && !set_fire &&
        elapsed_ticks >= timeout_limit) begin
      expire = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= stw_pkg::STW_ARMED;
    end else begin
      unique case (state_q)
        stw_pkg::STW_ARMED: begin
          if (expire) begin
            state_q <= stw_pkg::STW_EXPIRED;
          end
        end
        stw_pkg::STW_EXPIRED: begin
          state_q <= stw_pkg::STW_EXPIRED;
        end
        // An upset state bit is treated as expiry, since failing safe is
        // the whole point of this block.
        default: begin
          state_q <= stw_pkg::STW_EXPIRED;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown outputs. Halt and outputs-off have a flop each so that every
  // pin has its own driver; both set on the same expiry, and only a system
  // reset clears them, whatever the processor does afterwards.

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      controller_halt <= 1'b0;
    end else if (expire || state_q != stw_pkg::STW_ARMED) begin
      controller_halt <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      io_outputs_off <= 1'b0;
    end else if (expire || state_q != stw_pkg::STW_ARMED) begin
      io_outputs_off <= 1'b1;
    end
  end

endmodule

// ---- hw/stw_pkg.sv ----
package stw_pkg;

  // Clock rate and tick period.
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

  // Timeout setting range, in ticks.
  localparam int unsigned LIMIT_W       = 7;
  localparam logic [6:0]  LIMIT_MIN     = 7'h05;
  localparam logic [6:0]  LIMIT_MAX     = 7'h78;
  // A quarter second is 25 ticks.
  localparam logic [6:0]  LIMIT_DEFAULT = 7'h19;

  typedef enum logic [1:0] {
    STW_ARMED   = 2'b00,
    STW_EXPIRED = 2'b01
  } stw_state_t;

  typedef struct packed {
    logic       load;
    logic [6:0] ticks;
  } stw_load_t;

endpackage

// ---- hw/stw_tick_div.sv ----
`timescale 1ns/1ps
module stw_tick_div #(
  parameter int unsigned CYCLES = stw_pkg::TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic restart,
  output logic      tick
);

  initial begin
    if (CYCLES < 2) begin
      $error("stw_tick_div: CYCLES must be at least 2");
    end
  end

  localparam int unsigned CW = $clog2(CYCLES);

  logic [CW-1:0] cnt_q;

  // Restart realigns the divider so a retrigger always sees a full tick.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == CW'(CYCLES - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule

// ---- test/stw_props.sv ----
`timescale 1ns/1ps
module stw_props (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       set_timeout_command,
  input wire logic [6:0] set_timeout_ticks,
  input wire logic       set_timeout_edge_mode,
  input wire logic       retrigger_command,
  input wire logic       retrigger_edge_mode,
  input wire logic       controller_halt,
  input wire logic       io_outputs_off,
  input wire logic [6:0] timeout_limit,
  input wire logic [6:0] elapsed_ticks,
  input wire logic       setting_rejected
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic lv;
  assign lv = set_timeout_command && !set_timeout_edge_mode;
  // Over the limit with no restart this cycle: the next edge must halt.
  sequence s_over;
    !controller_halt && elapsed_ticks >= timeout_limit &&
    !retrigger_command && !set_timeout_command;
  endsequence
  AST_EXPIRE: assert property (s_over |=> controller_halt)
    else $error("limit passed without halt");
  AST_OFF: assert property (io_outputs_off == controller_halt)
    else $error("outputs off differs from halt");
  AST_STICKY: assert property (controller_halt |=> controller_halt)
    else $error("halt dropped without reset");
  AST_EARLY: assert property (!controller_halt &&
    elapsed_ticks < timeout_limit |=> !controller_halt)
    else $error("halt before limit");
  AST_CLEAR: assert property (retrigger_command && !retrigger_edge_mode
    && !controller_halt |=> elapsed_ticks == 7'h00)
    else $error("retrigger did not clear count");
  AST_KEEP: assert property (!set_timeout_command |=>
    $stable(timeout_limit)) else $error("limit changed without load");
  AST_LOAD: assert property (lv && set_timeout_ticks inside {[5:120]}
    |=> timeout_limit == $past(set_timeout_ticks))
    else $error("limit not loaded");
  AST_REJ: assert property (lv && set_timeout_ticks < 7'h05 |=>
    setting_rejected && $stable(timeout_limit))
    else $error("short limit taken");
  AST_SAT: assert property (elapsed_ticks <= timeout_limit)
    else $error("count passed limit");
endmodule
bind stw_scan_limit_watchdog stw_props u_stw_props (.core_clk, .reset,
  .set_timeout_command, .set_timeout_ticks, .set_timeout_edge_mode,
  .retrigger_command, .retrigger_edge_mode, .controller_halt,
  .io_outputs_off, .timeout_limit, .elapsed_ticks, .setting_rejected);

// ---- test/stw_cpu_model.sv ----
`timescale 1ns/1ps
module stw_cpu_model (
  input  wire logic       core_clk,
  input  wire logic       run,
  input  wire logic       hold,
  input  wire logic [7:0] scan,
  output logic            retrig
);
  logic [7:0] cnt_q;
  // A stalled processor just stops triggering, which is the fault to catch.
  // A shorter scan set mid-count triggers at once rather than wrapping, and
  // hold models a trigger line stuck high. Run low also clears the count.
  always_ff @(posedge core_clk) begin
    cnt_q  <= (!run || cnt_q >= scan) ? 8'h00 : cnt_q + 8'h01;
    retrig <= run && (hold || cnt_q >= scan);
  end
endmodule

// ---- test/test_scan_time_watchdog.sv ----
`timescale 1ns/1ps
module test_scan_time_watchdog;
  logic       core_clk, reset, ld, ld_edge, run, retrig, halt, off, rej;
  logic       hold, rt_edge;
  logic [6:0] n, lim, el;
  logic [7:0] scan;
  int         errors, n_compared, cyc;
  stw_scan_limit_watchdog #(.TICK_CYCLES(4)) u_stw_scan_limit_watchdog (
    .core_clk(core_clk), .reset(reset), .set_timeout_command(ld),
    .set_timeout_ticks(n), .set_timeout_edge_mode(ld_edge),
    .retrigger_command(retrig), .retrigger_edge_mode(rt_edge),
    .controller_halt(halt), .io_outputs_off(off), .timeout_limit(lim),
    .elapsed_ticks(el), .setting_rejected(rej));
  stw_cpu_model u_stw_cpu_model (.core_clk(core_clk), .run(run), .hold(hold),
    .scan(scan), .retrig(retrig));
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (++cyc == 3000) begin
    errors++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic ck(input logic [6:0] g, e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic load(input logic [6:0] v);
    n = v;
    ld = 1;
    step(1);
    ld = 0;
    step(1);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_limits;
    load(7'h04);
    ck(rej, 1);
    ck(lim, 7'h19);
    load(7'h79);
    ck(lim, 7'h19);
    ld_edge = 1;
    n = 7'h78;
    ld = 1;
    step(1);
    n = 7'h06;
    step(2);
    ld = 0;
    ck(lim, 7'h78);
    ld_edge = 0;
    load(7'h05);
    ck(lim, 7'h05);
    ck(rej, 0);
    $display("limits test done");
  endtask
  task automatic t_expire;
    scan = 8'h0f;
    step(200);
    ck(halt, 0);
    run = 0;
    for (int i = 0; i < 60 && !halt; i++) step(1);
    ck(halt, 1);
    ck(off, 1);
    ck(el, 7'h05);
    run = 1;
    step(40);
    ck(halt, 1);
    $display("expire test done");
  endtask
  task automatic t_edge_retrig;
    rt_edge = 1;
    hold = 1;
    step(60);
    ck(halt, 0);
    for (int i = 0; i < 120 && !halt; i++) step(1);
    ck(halt, 1);
    ck(el, 7'h19);
    $display("edge retrigger test done");
  endtask
  initial begin
    {reset, ld, ld_edge, run, n, scan} = {4'h8, 7'h05, 8'h3c};
    hold = 0;
    rt_edge = 0;
    step(6);
    reset = 0;
    run = 1;
    ck(lim, 7'h19);
    step(400);
    ck(halt, 0);
    t_limits();
    t_expire();
    reset = 1;
    step(2);
    reset = 0;
    ck(lim, 7'h19);
    ck(halt, 0);
    t_edge_retrig();
    tally_and_finish();
  end
endmodule
